/* File: hw/scpc_pkg.sv */
// package for the serial and pin control front end
// shared by the design module, its bound checker and the bench; no other files assumed
package scpc_pkg;
    // audio data interface formats
    typedef enum logic [1:0] {
        SCPC_FMT_I2S   = 2'h0,
        SCPC_FMT_LSB16 = 2'h1,
        SCPC_FMT_LSB20 = 2'h2,
        SCPC_FMT_LSB24 = 2'h3
    } scpc_fmt_t;

    // serial engine states, gray along the usual path
    typedef enum logic [1:0] {
        SCPC_ST_ADDR = 2'h0,
        SCPC_ST_REG  = 2'h1,
        SCPC_ST_DATA = 2'h3,
        SCPC_ST_SKIP = 2'h2
    } scpc_state_t;

    // settings handed to the datapath
    typedef struct packed {
        scpc_fmt_t  fmt;
        logic       chan_sel;
        logic       clk_follow_wsi;
        logic       dac_from_decoder;
        logic       soft_mute;
    } scpc_settings_t;

    // lock sources from the datapath
    typedef struct packed {
        logic pll_locked;
        logic dec_locked;
        logic pcm_detected;
    } scpc_lock_t;

    // device address byte layout
    localparam int SCPC_TYPE_LSB = 0;
    localparam int SCPC_DEVADDR_LSB = 2;
    localparam logic [1:0] SCPC_TYPE_WRITE = 2'h2; // bit1=1 bit0=0
    localparam logic [1:0] SCPC_TYPE_READ = 2'h3;  // bit1=1 bit0=1
    localparam logic [5:0] SCPC_DEVADDR_DEFAULT = 6'h06; // arbitrary default
    // register address byte layout
    localparam int SCPC_RW_BIT = 0;
    localparam int SCPC_REGADDR_LSB = 1;
    // register number and field holding the soft mute bit
    localparam logic [6:0] SCPC_REG_SOUND = 7'h10;
    localparam int SCPC_MUTE_BIT = 0;
    // serial-mode defaults (static mode takes settings from pins, soft mute off)
    localparam logic SCPC_DEF_CHAN = 1'h0;
    localparam logic SCPC_DEF_CLKSRC = 1'h0;
    localparam logic SCPC_DEF_DACSRC = 1'h1;
    localparam logic SCPC_DEF_MUTE = 1'h1;
    localparam logic [3:0] SCPC_BIT_LAST = 4'h7;
endpackage

/* File: hw/scpc_ctrl.sv */
// serial and pin control front end: static strap decode, three-wire serial
// slave with register write and read return, lock and emphasis status pins.
// assumes the register store is outside: writes leave as a strobe with
// address and word, reads are answered by a combinational lookup port.
`timescale 1ns/1ps

module scpc_ctrl
    import scpc_pkg::*;
#(
    parameter logic [5:0] DEV_ADDR = SCPC_DEVADDR_DEFAULT
) (
    // system
    input wire logic clk_i,
    input wire logic srst_i,
    // straps and static pins
    input wire logic control_style_select_i,
    input wire logic input_channel_select_i,
    input wire logic clock_source_select_i,
    input wire logic dac_source_select_i,
    // serial bus; data line is two-way
    input wire logic ctl_serial_clock_line_i,
    input wire logic ctl_serial_phase_line_i,
    input wire logic ctl_serial_data_line_i,
    output logic ctl_serial_data_line_o,
    output logic ctl_serial_data_line_oe_o,
    // register store side
    output logic reg_wr_o,
    output logic [6:0] reg_addr_o,
    output logic [15:0] reg_wdata_o,
    input wire logic [15:0] reg_rdata_i,
    input wire logic reg_valid_i,
    // datapath status in, settings out
    input wire scpc_lock_t lock_src_i,
    input wire logic [1:0] emphasis_code_i,
    output scpc_settings_t settings_o,
    output logic lock_o,
    output logic emphasis_code_bit0_o,
    output logic emphasis_code_bit1_o
);
    // two-flop synchronisers for every pin
    logic [1:0] sel_s_reg, clk_s_reg, mode_s_reg, data_s_reg;
    logic [1:0] chan_s_reg, cks_s_reg, dsrc_s_reg;
    logic clk_d_reg;
    always_ff @(posedge clk_i) begin
        sel_s_reg <= {sel_s_reg[0], control_style_select_i};
        clk_s_reg <= {clk_s_reg[0], ctl_serial_clock_line_i};
        mode_s_reg <= {mode_s_reg[0], ctl_serial_phase_line_i};
        data_s_reg <= {data_s_reg[0], ctl_serial_data_line_i};
        chan_s_reg <= {chan_s_reg[0], input_channel_select_i};
        cks_s_reg <= {cks_s_reg[0], clock_source_select_i};
        dsrc_s_reg <= {dsrc_s_reg[0], dac_source_select_i};
        clk_d_reg <= clk_s_reg[1];
    end

    logic static_mode;
    logic serial_mode;
    logic clk_rise;
    logic clk_fall;
    assign static_mode = sel_s_reg[1];
    assign serial_mode = ~sel_s_reg[1];
    // edges found from synchronised copies only; link clock is slow (200 ns)
    assign clk_rise = serial_mode & clk_s_reg[1] & ~clk_d_reg;
    assign clk_fall = serial_mode & ~clk_s_reg[1] & clk_d_reg;

    // phase change restarts byte framing
    logic mode_d_reg;
    logic mode_change;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mode_d_reg <= 1'h0;
        end else begin
            mode_d_reg <= mode_s_reg[1];
        end
    end
    assign mode_change = mode_d_reg != mode_s_reg[1];

    // shift register: bit 0 first, so new bits enter at the top
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic byte_done;
    always_ff @(posedge clk_i) begin
        if (srst_i || mode_change || static_mode) begin
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
        end else if (clk_rise) begin
            shift_reg <= {data_s_reg[1], shift_reg[7:1]};
            bit_cnt_reg <= (bit_cnt_reg == SCPC_BIT_LAST) ? 4'h0 : bit_cnt_reg + 4'h1;
        end
    end
    // full byte after eighth rising clock
    assign byte_done = clk_rise && bit_cnt_reg == SCPC_BIT_LAST;

    logic [7:0] rx_byte;
    assign rx_byte = {data_s_reg[1], shift_reg[7:1]};

    // transaction state
    scpc_state_t state_reg;
    logic read_xfer_reg;
    logic [1:0] data_idx_reg;
    logic [6:0] sel_addr_reg;
    logic [15:0] word_reg;
    logic [7:0] tx_reg;
    logic tx_en_reg;
    logic [1:0] addr_type;
    assign addr_type = rx_byte[SCPC_TYPE_LSB +: 2];

    always_ff @(posedge clk_i) begin
        if (srst_i || static_mode) begin
            state_reg <= SCPC_ST_ADDR;
            read_xfer_reg <= 1'h0;
            data_idx_reg <= 2'h0;
        end else if (byte_done && !mode_s_reg[1]) begin
            // address phase: mode low, eight clocks
            data_idx_reg <= 2'h0;
            if (rx_byte[SCPC_DEVADDR_LSB +: 6] == DEV_ADDR && addr_type == SCPC_TYPE_WRITE) begin
                state_reg <= SCPC_ST_REG;
                read_xfer_reg <= 1'h0;
            end else if (rx_byte[SCPC_DEVADDR_LSB +: 6] == DEV_ADDR
                         && addr_type == SCPC_TYPE_READ) begin
                state_reg <= SCPC_ST_DATA;
                read_xfer_reg <= 1'h1;
            end else begin
                state_reg <= SCPC_ST_SKIP;
            end
        end else if (byte_done && mode_s_reg[1]) begin
            // data phase bytes
            unique case (state_reg)
                SCPC_ST_REG: begin
                    state_reg <= SCPC_ST_DATA;
                end
                SCPC_ST_DATA: begin
                    if (data_idx_reg != 2'h3) begin
                        data_idx_reg <= data_idx_reg + 2'h1;
                    end
                end
                SCPC_ST_ADDR, SCPC_ST_SKIP: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // register address byte: flag and seven-bit address
    logic rd_pending_reg;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sel_addr_reg <= 7'h00;
            rd_pending_reg <= 1'h0;
        end else if (byte_done && mode_s_reg[1] && state_reg == SCPC_ST_REG) begin
            sel_addr_reg <= rx_byte[SCPC_REGADDR_LSB +: 7];
            rd_pending_reg <= rx_byte[SCPC_RW_BIT];
        end
    end

    // write word assembly, high byte first; strobe after second byte
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            word_reg <= 16'h0000;
            reg_wr_o <= 1'h0;
        end else begin
            reg_wr_o <= 1'h0;
            if (byte_done && mode_s_reg[1] && state_reg == SCPC_ST_DATA
                && !read_xfer_reg && !rd_pending_reg) begin
                if (data_idx_reg == 2'h0) begin
                    word_reg[15:8] <= rx_byte;
                end else if (data_idx_reg == 2'h1) begin
                    word_reg[7:0] <= rx_byte;
                    reg_wr_o <= 1'h1;
                end
            end
        end
    end
    assign reg_addr_o = sel_addr_reg;
    assign reg_wdata_o = word_reg;

    // read return: address byte with validity flag, then high and low data
    logic [7:0] tx_load;
    logic [15:0] rd_word_reg;
    always_comb begin
        tx_load = 8'h00;
        unique case (data_idx_reg)
            2'h0: tx_load = {sel_addr_reg, ~reg_valid_i};
            2'h1: tx_load = rd_word_reg[15:8];
            2'h2: tx_load = rd_word_reg[7:0];
            2'h3: tx_load = 8'h00;
        endcase
    end

    // device drives data line on falling clock so host samples on rising
    logic tx_loaded_reg;
    always_ff @(posedge clk_i) begin
        if (srst_i || static_mode) begin
            tx_reg <= 8'h00;
            tx_en_reg <= 1'h0;
            tx_loaded_reg <= 1'h0;
            rd_word_reg <= 16'h0000;
        end else if (!(read_xfer_reg && mode_s_reg[1] && state_reg == SCPC_ST_DATA)
                     || data_idx_reg == 2'h3) begin
            tx_en_reg <= 1'h0;
            tx_loaded_reg <= 1'h0;
        end else if (!tx_loaded_reg || byte_done) begin
            // first bit stands before the first rising clock of the byte
            tx_reg <= byte_done ? 8'h00 : tx_load;
            tx_loaded_reg <= !byte_done;
            tx_en_reg <= rd_pending_reg;
            if (data_idx_reg == 2'h0 && !tx_loaded_reg) begin
                rd_word_reg <= reg_rdata_i;
            end
        end else if (clk_fall && bit_cnt_reg != 4'h0) begin
            tx_reg <= {1'h0, tx_reg[7:1]};
        end
    end
    assign ctl_serial_data_line_o = tx_reg[0];
    assign ctl_serial_data_line_oe_o = tx_en_reg;

    // soft mute: set at start-up in serial mode until host clears it
    logic mute_reg;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mute_reg <= SCPC_DEF_MUTE;
        end else if (reg_wr_o && sel_addr_reg == SCPC_REG_SOUND) begin
            mute_reg <= word_reg[SCPC_MUTE_BIT];
        end
    end

    // settings out, registered
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            settings_o <= '{SCPC_FMT_I2S, SCPC_DEF_CHAN, SCPC_DEF_CLKSRC,
                            SCPC_DEF_DACSRC, SCPC_DEF_MUTE};
        end else if (static_mode) begin
            settings_o.fmt <= scpc_fmt_t'({mode_s_reg[1], data_s_reg[1]});
            settings_o.chan_sel <= chan_s_reg[1];
            settings_o.clk_follow_wsi <= cks_s_reg[1];
            settings_o.dac_from_decoder <= dsrc_s_reg[1];
            settings_o.soft_mute <= 1'h0;
        end else begin
            // serial mode: register store owns the rest; mute tracked here
            settings_o.fmt <= SCPC_FMT_I2S;
            settings_o.chan_sel <= SCPC_DEF_CHAN;
            settings_o.clk_follow_wsi <= SCPC_DEF_CLKSRC;
            settings_o.dac_from_decoder <= SCPC_DEF_DACSRC;
            settings_o.soft_mute <= mute_reg;
        end
    end

    // status pins
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lock_o <= 1'h0;
            emphasis_code_bit0_o <= 1'h0;
            emphasis_code_bit1_o <= 1'h0;
        end else begin
            if (static_mode) begin
                lock_o <= lock_src_i.pll_locked & lock_src_i.dec_locked
                          & lock_src_i.pcm_detected;
            end else begin
                lock_o <= lock_src_i.pll_locked & lock_src_i.dec_locked;
            end
            emphasis_code_bit0_o <= emphasis_code_i[0];
            emphasis_code_bit1_o <= emphasis_code_i[1];
        end
    end
endmodule

/* File: testbench/scpc_ctrl_props.sv */
// checker for the serial and pin control front end
// sees only the ports of scpc_ctrl; bound into every instance below
`timescale 1ns/1ps
module scpc_ctrl_props
    import scpc_pkg::*;
(
    // clock, reset and pins
    input wire logic clk_i, srst_i, control_style_select_i,
    input wire logic input_channel_select_i, clock_source_select_i, dac_source_select_i,
    input wire logic ctl_serial_clock_line_i, ctl_serial_phase_line_i, ctl_serial_data_line_i,
    input wire scpc_lock_t lock_src_i,
    input wire logic [1:0] emphasis_code_i,
    // outputs
    input wire logic ctl_serial_data_line_oe_o, reg_wr_o, lock_o,
    input wire logic emphasis_code_bit0_o, emphasis_code_bit1_o,
    input wire logic [6:0] reg_addr_o,
    input wire logic [15:0] reg_wdata_o,
    input wire scpc_settings_t settings_o
);
    logic sclk_q;
    logic [3:0] since_rise;
    wire logic [4:0] pins = {ctl_serial_phase_line_i, ctl_serial_data_line_i,
        input_channel_select_i, clock_source_select_i, dac_source_select_i};
    wire logic clr = reg_wr_o && reg_addr_o == SCPC_REG_SOUND && !reg_wdata_o[SCPC_MUTE_BIT];
    // age of the last serial clock rise; saturates so a quiet bus never wraps
    always_ff @(posedge clk_i) begin
        sclk_q <= ctl_serial_clock_line_i;
        if (srst_i || (ctl_serial_clock_line_i && !sclk_q)) begin
            since_rise <= 4'h0;
        end else if (since_rise != 4'hf) begin
            since_rise <= since_rise + 4'h1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    property p_wr_pulse; reg_wr_o |=> !reg_wr_o; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("long write strobe");
    property p_wr_sync; reg_wr_o |-> since_rise >= 4'h2 && since_rise <= 4'h9; endproperty
    a_wr_sync: assert property (p_wr_sync) else $error("write not tied to clock");
    property p_quiet; control_style_select_i [*8] |-> !reg_wr_o && !ctl_serial_data_line_oe_o;
    endproperty
    a_quiet: assert property (p_quiet) else $error("bus active in static");
    property p_pins; (control_style_select_i && $stable(pins)) [*6] |-> settings_o == {pins, 1'b0};
    endproperty
    a_pins: assert property (p_pins) else $error("static settings wrong");
    property p_lk_st; control_style_select_i [*6] |-> lock_o == $past(&lock_src_i); endproperty
    a_lk_st: assert property (p_lk_st) else $error("static lock wrong");
    property p_lk_se; !control_style_select_i [*6] |->
        lock_o == $past(lock_src_i.pll_locked && lock_src_i.dec_locked); endproperty
    a_lk_se: assert property (p_lk_se) else $error("serial lock wrong");
    property p_emph; !$past(srst_i) |->
        {emphasis_code_bit1_o, emphasis_code_bit0_o} == $past(emphasis_code_i); endproperty
    a_emph: assert property (p_emph) else $error("emphasis wrong");
    property p_mute; $fell(settings_o.soft_mute) && !control_style_select_i |->
        clr || $past(clr) || $past(clr, 2); endproperty
    a_mute: assert property (p_mute) else $error("mute cleared unasked");
    c_write: cover property (reg_wr_o);
    c_drive: cover property (ctl_serial_data_line_oe_o);
    c_unmute: cover property ($fell(settings_o.soft_mute));
endmodule
bind scpc_ctrl scpc_ctrl_props i_scpc_ctrl_props (.clk_i, .srst_i, .control_style_select_i,
    .input_channel_select_i, .clock_source_select_i, .dac_source_select_i,
    .ctl_serial_clock_line_i, .ctl_serial_phase_line_i, .ctl_serial_data_line_i, .lock_src_i,
    .emphasis_code_i, .ctl_serial_data_line_oe_o, .reg_wr_o, .lock_o, .emphasis_code_bit0_o,
    .emphasis_code_bit1_o, .reg_addr_o, .reg_wdata_o, .settings_o);

/* File: testbench/scpc_host_model.sv */
// microcontroller side of the three-wire control bus
// paced by the system clock; the bench calls its tasks
`timescale 1ns/1ps
module scpc_host_model (
    // pacing clock
    input wire logic clk_i,
    // device half of the two-way data line
    input wire logic dev_d_i, dev_oe_i,
    // bus lines toward the device
    output logic sclk_o, phase_o, line_o
);
    logic drv = 1'b0, en = 1'b1, last = 1'b0;
    // a released line shows the inverse of its last level, never a stale copy
    assign line_o = dev_oe_i ? dev_d_i : (en ? drv : ~last);
    always @(posedge clk_i) begin
        last <= line_o;
    end
    initial begin
        sclk_o = 1'b0;
        phase_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // static straps share the phase and data lines; clock held low
    task automatic strap(input logic p, input logic d);
        sclk_o = 1'b0;
        phase_o = p;
        drv = d;
        en = 1'b1;
    endtask
    // one rising clock, left high, in an idle data phase, needed once after power-up
    task automatic wake();
        phase_o = 1'b1;
        tick(8);
        sclk_o = 1'b1;
        tick(8);
    endtask
    // one byte, lsb first, 200 ns per bit; clock stands high between bytes
    task automatic xfer(input logic p, input logic rd, input logic [7:0] b, output logic [7:0] r);
        phase_o = p;
        en = !rd;
        tick(8);
        for (int i = 0; i < 8; i++) begin
            sclk_o = 1'b0;
            drv = b[i];
            tick(4);
            // take the device's bit as the clock rises, before it moves on to the next byte
            r[i] = line_o;
            sclk_o = 1'b1;
            tick(4);
        end
    endtask
endmodule

/* File: testbench/scpc_ctrl_tb_top.sv */
// self-checking bench for scpc_ctrl
// needs the package, the design, its bound checker and scpc_host_model
`timescale 1ns/1ps
module scpc_ctrl_tb_top;
    import scpc_pkg::*;
    localparam logic [5:0] DEV = 6'h2d; // arbitrary device address
    logic clk_i = 1'b0, srst_i = 1'b1, sel = 1'b1, chan = 1'b0, csrc = 1'b0, dsrc = 1'b0;
    logic smp = 1'b0, rdm = 1'b0, exp_mute = 1'b1;
    logic sclk, ph, line, dq, doe, wr, lock, e0, e1, valid;
    logic [1:0] emph = 2'h0;
    logic [6:0] ra, a;
    logic [7:0] rb;
    logic [15:0] wd, rdat;
    logic [15:0] store [128];
    logic [31:0] seed = 32'h00015f36, got, want, r;
    logic [31:0] exp_q [$];
    scpc_lock_t lsrc = 3'h0;
    scpc_settings_t st;
    int num_errors = 0, checks = 0;
    always #12.5 clk_i = ~clk_i;
    // register store behind the lookup port; one address is invalid
    assign rdat = store[ra];
    assign valid = ra != 7'h7f;
    always @(posedge clk_i) begin
        if (wr) begin
            store[ra] <= wd;
        end
    end
    scpc_ctrl #(.DEV_ADDR(DEV)) i_scpc_ctrl (.clk_i, .srst_i, .control_style_select_i(sel),
        .input_channel_select_i(chan), .clock_source_select_i(csrc), .dac_source_select_i(dsrc),
        .ctl_serial_clock_line_i(sclk), .ctl_serial_phase_line_i(ph),
        .ctl_serial_data_line_i(line), .ctl_serial_data_line_o(dq),
        .ctl_serial_data_line_oe_o(doe), .reg_wr_o(wr), .reg_addr_o(ra), .reg_wdata_o(wd),
        .reg_rdata_i(rdat), .reg_valid_i(valid), .lock_src_i(lsrc), .emphasis_code_i(emph),
        .settings_o(st), .lock_o(lock), .emphasis_code_bit0_o(e0), .emphasis_code_bit1_o(e1));
    scpc_host_model i_scpc_host_model (.clk_i, .dev_d_i(dq), .dev_oe_i(doe), .sclk_o(sclk),
        .phase_o(ph), .line_o(line));
    // each result takes the oldest note; an empty queue means a stray result
    always @(posedge clk_i) begin
        if (wr || smp) begin
            got = wr ? {9'h001, ra, wd} : (rdm ? {24'h0, rb} : {23'h0, st, lock, e1, e0});
            want = exp_q.size() > 0 ? exp_q.pop_front() : 32'hx;
            checks++;
            if (want !== got) begin
                num_errors++;
                $display("unexpected at %0t: want %h got %h", $time, want, got);
            end
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic close_out();
        num_errors += exp_q.size();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic note(input logic [31:0] e, input logic rd);
        exp_q.push_back(e);
        rdm = rd;
        smp = 1'b1;
        tick(1);
        smp = 1'b0;
    endtask
    // static settings mirror the pins; serial ones hold defaults and writes
    task automatic status(input logic s);
        // status pins are registered: let fresh lock and emphasis inputs reach them first
        tick(2);
        note({23'h0, s ? {ph, line, chan, csrc, dsrc, 1'b0} : {2'h0, SCPC_DEF_CHAN,
            SCPC_DEF_CLKSRC, SCPC_DEF_DACSRC, exp_mute},
            s ? &lsrc : lsrc.pll_locked & lsrc.dec_locked, emph}, 1'b0);
    endtask
    task automatic byte_io(input logic p, input logic rd, input logic [7:0] v);
        i_scpc_host_model.xfer(p, rd, v, rb);
    endtask
    task automatic wr_reg(input logic [5:0] da, input logic [1:0] ty, input logic [6:0] ad,
            input logic [15:0] d);
        if (da == DEV && ty == SCPC_TYPE_WRITE) begin
            exp_q.push_back({9'h001, ad, d});
        end
        byte_io(1'b0, 1'b0, {da, ty});
        byte_io(1'b1, 1'b0, {ad, 1'b0});
        byte_io(1'b1, 1'b0, d[15:8]);
        byte_io(1'b1, 1'b0, d[7:0]);
        for (int k = 0; k < 20 && exp_q.size() > 0; k++) begin
            @(posedge clk_i);
        end
        if (exp_q.size() > 0) begin
            close_out();
        end
        tick(8);
    endtask
    // prepare read, then read: address with validity flag, high byte, low byte
    task automatic rd_reg(input logic [6:0] ad, input logic [15:0] d);
        logic [7:0] w [3];
        w = '{{ad, ad == 7'h7f}, d[15:8], d[7:0]};
        byte_io(1'b0, 1'b0, {DEV, SCPC_TYPE_WRITE});
        byte_io(1'b1, 1'b0, {ad, 1'b1});
        byte_io(1'b0, 1'b0, {DEV, SCPC_TYPE_READ});
        for (int i = 0; i < 3; i++) begin
            byte_io(1'b1, 1'b1, 8'h00);
            note({24'h0, w[i]}, 1'b1);
        end
    endtask
    initial begin
        for (int i = 0; i < 128; i++) begin
            store[i] = 16'h0000;
        end
        tick(5);
        srst_i = 1'b0;
        // every format and emphasis code, random straps and lock sources
        for (int i = 0; i < 16; i++) begin
            r = xs();
            i_scpc_host_model.strap(i[3], i[2]);
            {chan, csrc, dsrc, lsrc} = r[5:0];
            emph = i[1:0];
            tick(6);
            status(1'b1);
        end
        sel = 1'b0;
        i_scpc_host_model.wake();
        lsrc = 3'h6;
        status(1'b0);
        // foreign address and unused transfer types change nothing
        wr_reg(DEV ^ 6'h01, SCPC_TYPE_WRITE, SCPC_REG_SOUND, 16'h0000);
        wr_reg(DEV, 2'h0, SCPC_REG_SOUND, 16'h0000);
        wr_reg(DEV, 2'h1, SCPC_REG_SOUND, 16'h0000);
        status(1'b0);
        wr_reg(DEV, SCPC_TYPE_WRITE, SCPC_REG_SOUND, 16'h0000);
        exp_mute = 1'b0;
        lsrc = 3'h5;
        emph = 2'h3;
        status(1'b0);
        for (int i = 0; i < 3; i++) begin
            r = xs();
            a = {2'h1, r[4:0]};
            wr_reg(DEV, SCPC_TYPE_WRITE, a, r[31:16]);
            rd_reg(a, r[31:16]);
        end
        rd_reg(7'h7f, 16'h0000);
        close_out();
    end
endmodule
